// ===== tb.sv
`timescale 1ns/1ps
module tb;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic cs_b, rd_b, wr_b, ale, cmd_data_select, muxed_mode, bus_cfg_sel_lo, bus_cfg_sel_hi;
   logic muxed_addr_data_line0_in, muxed_addr_data_line0_out, muxed_addr_data_line0_oe;
   logic [15:0] data_in, data_out, data_oe, cmd_wr_data, cmd_rd_data, rx_data, tx_data, q, v;
   logic [1:0] bus_cfg;
   logic bus_cfg_reserved, cmd_wr_pulse, cmd_rd_pulse, rx_valid, rx_ready, tx_valid, tx_ready;
   logic dma_enable, dma_req_pol, dma_grant_pol, dma_finish_pol, dma_request_out, dma_done;
   logic dma_grant_in, dma_finish_force_in, int_event, int_active_high, int_pulse_mode;
   logic int_clear, int_out, prog_clock_output;
   logic [7:0] clk_div;
   logic [15:0] wq[$], rq[$], txq[$], exq[$];
   int fail_count = 0, comparisons = 0, cyc = 0, nrd = 0, ndone = 0, k, n;
   // ----------------------------------------------------------------
   // Clock, design, partner and monitors
   // ----------------------------------------------------------------
   always #12.5 core_clk = ~core_clk;
   uhp_host_port #(.WIDTH(16), .DEPTH(32)) u_dut (.core_clk, .rst_b, .cs_b, .rd_b, .wr_b, .ale,
      .cmd_data_select, .muxed_mode, .data_in, .data_out, .data_oe, .muxed_addr_data_line0_in,
      .muxed_addr_data_line0_out, .muxed_addr_data_line0_oe, .bus_cfg_sel_lo, .bus_cfg_sel_hi,
      .bus_cfg, .bus_cfg_reserved, .cmd_wr_pulse, .cmd_wr_data, .cmd_rd_pulse, .cmd_rd_data,
      .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_ready, .dma_enable, .dma_req_pol,
      .dma_grant_pol, .dma_finish_pol, .dma_request_out, .dma_grant_in, .dma_finish_force_in,
      .dma_done, .int_event, .int_active_high, .int_pulse_mode, .int_clear, .int_out, .clk_div,
      .prog_clock_output);
   uhp_host_model u_host (.core_clk, .data_out, .data_oe, .line0_out(muxed_addr_data_line0_out),
      .line0_oe(muxed_addr_data_line0_oe), .cs_b, .rd_b, .wr_b, .ale, .cmd_data_select, .data_in,
      .line0_in(muxed_addr_data_line0_in), .dma_grant_in, .dma_finish_force_in);
   // Collects command writes, stream words and pulses; cuts a hang short.
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cmd_wr_pulse === 1'b1) wq.push_back(cmd_wr_data);
      if (rx_valid === 1'b1 && rx_ready === 1'b1) rq.push_back(rx_data);
      if (cmd_rd_pulse === 1'b1) nrd++;
      if (dma_done === 1'b1) ndone++;
      if (cyc == 20000)
      begin
         fail_count++;
         end_of_test();
      end
   end
   // ----------------------------------------------------------------
   // Checking helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      chk({15'h0000, g}, {15'h0000, e});
   endtask
   task automatic pop_chk(ref logic [15:0] qu[$], input logic [15:0] e);
      logic [15:0] g;
      g = 16'hxxxx;
      if (qu.size() > 0) g = qu.pop_front();
      chk(g, e);
   endtask
   function automatic logic [15:0] exp_rd(input logic m8, input logic [15:0] d);
      return m8 ? {8'h00, d[7:0]} : d;
   endfunction
   // Offers words to the read-side buffer; ready is judged at the falling edge before the take.
   task automatic push_tx(input int want);
      logic ok;
      k = 0;
      @(negedge core_clk);
      tx_data = 16'($urandom);
      tx_valid = 1'b1;
      for (int i = 0; i < 60 && k < want; i++)
      begin
         ok = (tx_ready === 1'b1);
         if (ok) txq.push_back(tx_data);
         @(negedge core_clk);
         k += int'(ok);
         if (ok) tx_data = 16'($urandom);
      end
      tx_valid = 1'b0;
   endtask
   task automatic end_of_test;
      $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {muxed_mode, bus_cfg_sel_lo, bus_cfg_sel_hi, rx_ready, tx_valid, dma_enable} = 6'h00;
      {int_event, int_pulse_mode, int_clear, dma_req_pol, dma_grant_pol, dma_finish_pol} = 6'h07;
      {cmd_rd_data, tx_data, int_active_high, clk_div} = {32'h0000_0000, 1'b1, 8'h03};
      void'($urandom(32'h8e113408));
      repeat (8) @(negedge core_clk);
      chk(data_oe, 16'h0000);
      chk_bit(int_out, 1'b0);
      chk_bit(dma_request_out, 1'b0);
      repeat (8) @(negedge core_clk);
      rst_b = 1'b1;
      repeat (20) @(negedge core_clk);
      // Command writes and reads with the separate select line.
      for (int i = 0; i < 3; i++)
      begin
         v = 16'($urandom);
         u_host.access(1'b1, 1'b1, 1'b1, v, q);
         pop_chk(wq, v);
         cmd_rd_data = 16'($urandom);
         n = nrd;
         u_host.access(1'b0, 1'b1, 1'b1, 16'h0000, q);
         chk(q, cmd_rd_data);
         chk(16'(nrd - n), 16'h0001);
      end
      u_host.access(1'b1, 1'b0, 1'b1, 16'h1234, q);
      chk(16'(wq.size()), 16'h0000);
      // Data writes overfill the stalled write buffer, then drain with random stalls.
      for (int i = 0; i < 34; i++)
      begin
         v = 16'($urandom);
         u_host.access(1'b1, 1'b1, 1'b0, v, q);
         if (i < 32) exq.push_back(v);
      end
      for (int i = 0; i < 300; i++) @(negedge core_clk) rx_ready = 1'($urandom);
      rx_ready = 1'b1;
      for (int i = 0; i < 32; i++) pop_chk(rq, exq.pop_front());
      chk(16'(rq.size()), 16'h0000);
      // Read buffer filled until it refuses, then drained by data reads.
      push_tx(40);
      chk(16'(k), 16'h0020);
      for (int i = 0; i < 32; i++)
      begin
         u_host.access(1'b0, 1'b1, 1'b0, 16'h0000, q);
         chk(q, txq.pop_front());
      end
      chk_bit(tx_ready, 1'b1);
      // Every bus configuration code, then a narrow read in mode 2.
      for (int i = 0; i < 4; i++)
      begin
         {bus_cfg_sel_hi, bus_cfg_sel_lo} = 2'(i);
         repeat (6) @(negedge core_clk);
         chk({14'h0000, bus_cfg}, 16'(i));
         chk_bit(bus_cfg_reserved, i[0]);
      end
      {bus_cfg_sel_hi, bus_cfg_sel_lo} = uhp_pkg::CFG_MODE8;
      cmd_rd_data = 16'($urandom);
      u_host.access(1'b0, 1'b1, 1'b1, 16'h0000, q);
      chk(q, exp_rd(1'b1, cmd_rd_data));
      {bus_cfg_sel_hi, bus_cfg_sel_lo} = uhp_pkg::CFG_MODE16;
      repeat (6) @(negedge core_clk);
      // Multiplexed bus: address phase chooses command or data, line 0 is bit 0.
      muxed_mode = 1'b1;
      for (int i = 0; i < 2; i++)
      begin
         v = 16'($urandom);
         v[0] = i[0];
         u_host.addr_phase(1'b1);
         u_host.access(1'b1, 1'b1, 1'b0, v, q);
         pop_chk(wq, v);
         cmd_rd_data = ~v;
         u_host.addr_phase(1'b1);
         u_host.access(1'b0, 1'b1, 1'b0, 16'h0000, q);
         chk(q, ~v);
         u_host.addr_phase(1'b0);
         u_host.access(1'b1, 1'b1, 1'b0, ~v, q);
         pop_chk(rq, ~v);
      end
      muxed_mode = 1'b0;
      // DMA handshake at both polarities, ended by the finish input.
      for (int p = 0; p < 2; p++)
      begin
         {dma_req_pol, dma_grant_pol, dma_finish_pol} = {3{p[0]}};
         u_host.dma_idle(p[0]);
         repeat (6) @(negedge core_clk);
         chk_bit(dma_request_out, ~p[0]);
         push_tx(3);
         dma_enable = 1'b1;
         for (int i = 0; i < 20 && dma_request_out !== p[0]; i++) @(negedge core_clk);
         chk_bit(dma_request_out, p[0]);
         n = ndone;
         u_host.dma_pulse(1'b0, p[0]);
         u_host.dma_pulse(1'b1, p[0]);
         repeat (6) @(negedge core_clk);
         chk(16'(ndone - n), 16'h0001);
         chk_bit(dma_request_out, ~p[0]);
         chk_bit(tx_ready, 1'b1);
         dma_enable = 1'b0;
         txq.delete();
      end
      // Interrupt output in every polarity and style.
      for (int m = 0; m < 4; m++)
      begin
         {int_pulse_mode, int_active_high} = 2'(m);
         repeat (4) @(negedge core_clk);
         chk_bit(int_out, ~m[0]);
         int_event = 1'b1;
         @(negedge core_clk) int_event = 1'b0;
         n = int'(int_out === m[0]);
         repeat (19) @(negedge core_clk) n += int'(int_out === m[0]);
         chk(16'(n), m[1] ? 16'(uhp_pkg::INT_PULSE_CYC) : 16'h0014);
         int_clear = 1'b1;
         repeat (2) @(negedge core_clk);
         int_clear = 1'b0;
         repeat (6) @(negedge core_clk);
         chk_bit(int_out, ~m[0]);
      end
      // Programmable clock output half period.
      clk_div = 8'(1 + $urandom % 6);
      repeat (40) @(negedge core_clk);
      v[0] = prog_clock_output;
      for (int i = 0; i < 40 && prog_clock_output === v[0]; i++) @(negedge core_clk);
      v[0] = prog_clock_output;
      for (n = 0; n < 300 && prog_clock_output === v[0]; n++) @(negedge core_clk);
      chk(16'(n), 16'(clk_div) + 16'h0001);
      end_of_test();
   end
endmodule

// ===== uhp_fifo.sv
`timescale 1ns/1ps
module uhp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic flush,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   // Handshakes are combinational from the fill count.
   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_q[rp_q];
   assign level = cnt_q;

   // Storage array needs no reset; only pointers and count carry state.
   always_ff @(posedge core_clk)
   begin
      if (push)
      begin
         mem_q[wp_q] <= in_data;
      end
   end

   // Pointers and count, flushed when a transfer is aborted.
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end
      else if (flush)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
         end
         if (pop)
         begin
            rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end
endmodule

// ===== uhp_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host microcontroller and DMA controller model
// ----------------------------------------------------------------
module uhp_host_model (
   input wire logic core_clk,
   input wire logic [15:0] data_out,
   input wire logic [15:0] data_oe,
   input wire logic line0_out,
   input wire logic line0_oe,
   output logic cs_b,
   output logic rd_b,
   output logic wr_b,
   output logic ale,
   output logic cmd_data_select,
   output logic [15:0] data_in,
   output logic line0_in,
   output logic dma_grant_in,
   output logic dma_finish_force_in
);
   logic [15:0] hd;
   logic hl;
   // The device wins where it drives; a released host bus shows the inverse pattern.
   assign data_in = (data_oe & data_out) | (~data_oe & hd);
   assign line0_in = line0_oe ? line0_out : hl;
   // Idle levels of the host pins.
   initial
   begin
      {cs_b, rd_b, wr_b} = 3'h7;
      ale = 1'b0;
      cmd_data_select = 1'b0;
      hd = 16'h5a5a;
      hl = 1'b0;
      {dma_grant_in, dma_finish_force_in} = 2'h0;
   end
   // Address phase of a multiplexed access; line 0 is latched as the strobe falls.
   task automatic addr_phase(input logic sel);
      @(negedge core_clk);
      hl = sel;
      ale = 1'b1;
      repeat (5) @(negedge core_clk);
      ale = 1'b0;
      repeat (5) @(negedge core_clk);
      hl = ~hl;
   endtask
   // One access; strobes stay low and high four cycles or more, data outlives the strobe.
   task automatic access(input logic wr, input logic cs, input logic sel, input logic [15:0] d,
                         output logic [15:0] q);
      @(negedge core_clk);
      cs_b = ~cs;
      cmd_data_select = sel;
      q = 16'h0000;
      hd = wr ? d : hd;
      hl = wr ? d[0] : hl;
      wr_b = ~wr;
      rd_b = wr;
      if (wr)
         repeat (6) @(negedge core_clk);
      for (int i = 0; i < 20 && !wr && data_oe[1] !== 1'b1; i++) @(negedge core_clk);
      if (!wr)
         q = {data_out[15:1], line0_oe ? line0_out : data_out[0]};
      {cs_b, rd_b, wr_b} = 3'h7;
      repeat (4) @(negedge core_clk);
      hd = ~hd;
      hl = ~hl;
      cmd_data_select = 1'b0;
      repeat (4) @(negedge core_clk);
   endtask
   // Puts both DMA inputs at their inactive level.
   task automatic dma_idle(input logic pol);
      @(negedge core_clk);
      dma_grant_in = ~pol;
      dma_finish_force_in = ~pol;
   endtask
   // Raises grant, or strobes finish, at the active level; a grant stays active until a finish ends it.
   task automatic dma_pulse(input logic fin, input logic pol);
      @(negedge core_clk);
      if (fin)
         dma_finish_force_in = pol;
      else
         dma_grant_in = pol;
      repeat (6) @(negedge core_clk);
      dma_finish_force_in = ~pol;
      if (fin)
         dma_grant_in = ~pol;
   endtask
endmodule

// ===== uhp_host_port.sv
`timescale 1ns/1ps
// How it works
// - Request output asserted when DMA data pending.
// - Interrupt: selectable level, selectable level/pulse.
// - ALE falling edge latches command/data select.
// - Muxed line carries data bit zero.
// - Separate select: high command, low data.
// - Async low reset plus internal power-on.
// - Reads drive sixteen bits in mode 0, low eight only in mode 2; in muxed mode bit zero goes out on line 0 instead.
// - Two select pins choose bus configuration.
// - Clock output toggles every programmed value plus one cycles.
// - Mode 0 sixteen-bit, mode 2 eight-bit.
// - Memory-like port with one address line.
module uhp_host_port #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic cs_b,
   input wire logic rd_b,
   input wire logic wr_b,
   input wire logic ale,
   input wire logic cmd_data_select,
   input wire logic muxed_mode,
   input wire logic [15:0] data_in,
   output logic [15:0] data_out,
   output logic [15:0] data_oe,
   input wire logic muxed_addr_data_line0_in,
   output logic muxed_addr_data_line0_out,
   output logic muxed_addr_data_line0_oe,
   input wire logic bus_cfg_sel_lo,
   input wire logic bus_cfg_sel_hi,
   output logic [1:0] bus_cfg,
   output logic bus_cfg_reserved,
   output logic cmd_wr_pulse,
   output logic [15:0] cmd_wr_data,
   output logic cmd_rd_pulse,
   input wire logic [15:0] cmd_rd_data,
   output logic [15:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   input wire logic [15:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic dma_enable,
   input wire logic dma_req_pol,
   input wire logic dma_grant_pol,
   input wire logic dma_finish_pol,
   output logic dma_request_out,
   input wire logic dma_grant_in,
   input wire logic dma_finish_force_in,
   output logic dma_done,
   input wire logic int_event,
   input wire logic int_active_high,
   input wire logic int_pulse_mode,
   input wire logic int_clear,
   output logic int_out,
   input wire logic [7:0] clk_div,
   output logic prog_clock_output
);
   // ----------------------------------------------------------------
   // Reset: pin reset plus internal power-on stretch
   // ----------------------------------------------------------------
   logic [4:0] por_cnt_q;
   logic live;

   // The internal reset holds the bus strobes, bus drivers and DMA start idle for a short count after release.
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         por_cnt_q <= '0;
      end
      else if (por_cnt_q != 5'(uhp_pkg::POR_CYC))
      begin
         por_cnt_q <= por_cnt_q + 5'h01;
      end
   end
   assign live = (por_cnt_q == 5'(uhp_pkg::POR_CYC));

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [9:0] ctl_s;
   logic [15:0] d_s;
   logic line0_s;
   uhp_sync #(.WIDTH(10)) u_sync_ctl (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .pin_in({~cs_b, ~rd_b, ~wr_b, ale, cmd_data_select, dma_grant_in,
               dma_finish_force_in, bus_cfg_sel_lo, bus_cfg_sel_hi, int_clear}),
      .pin_out(ctl_s)
   );
   uhp_sync #(.WIDTH(17)) u_sync_dat (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .pin_in({muxed_addr_data_line0_in, data_in}),
      .pin_out({line0_s, d_s})
   );
   logic cs_s, rd_s, wr_s, ale_s, sel_s, grant_s, fin_s;
   assign {cs_s, rd_s, wr_s, ale_s, sel_s, grant_s, fin_s} = ctl_s[9:3];

   // ----------------------------------------------------------------
   // Bus configuration
   // ----------------------------------------------------------------
   // Configuration straps are sampled continuously after sync.
   assign bus_cfg = {ctl_s[1], ctl_s[2]};
   assign bus_cfg_reserved = bus_cfg[0];
   logic narrow;
   assign narrow = (bus_cfg == uhp_pkg::CFG_MODE8);

   // ----------------------------------------------------------------
   // Address phase
   // ----------------------------------------------------------------
   logic ale_d_q;
   logic addr_q;
   logic rd_d_q;
   logic wr_d_q;
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ale_d_q <= 1'b0;
         rd_d_q <= 1'b0;
         wr_d_q <= 1'b0;
         addr_q <= 1'b0;
      end
      else
      begin
         ale_d_q <= ale_s;
         rd_d_q <= rd_s & cs_s;
         wr_d_q <= wr_s & cs_s;
         if (muxed_mode && ale_d_q && !ale_s)
         begin
            addr_q <= line0_s;
         end
      end
   end
   // Muxed mode uses the latched bit, separate mode the live select pin.
   logic is_cmd;
   assign is_cmd = muxed_mode ? addr_q : sel_s;

   // ----------------------------------------------------------------
   // Strobe decode
   // ----------------------------------------------------------------
   logic rd_go, wr_go, rd_end;
   assign rd_go = live && cs_s && rd_s && !rd_d_q;
   assign rd_end = rd_d_q && !(rd_s && cs_s);
   assign wr_go = live && wr_d_q && !(wr_s && cs_s);
   logic [15:0] wdat;
   assign wdat = narrow ? {8'h00, d_s[7:1], muxed_mode ? line0_s : d_s[0]}
                        : {d_s[15:1], muxed_mode ? line0_s : d_s[0]};
   logic [15:0] wdat_q;
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wdat_q <= 16'h0000;
      end
      else if (wr_s && cs_s)
      begin
         wdat_q <= wdat;
      end
   end
   assign cmd_wr_pulse = wr_go && is_cmd;
   assign cmd_wr_data = wdat_q;
   assign cmd_rd_pulse = rd_go && is_cmd;

   // ----------------------------------------------------------------
   // Write FIFO and read FIFO
   // ----------------------------------------------------------------
   logic dma_state_xfer;
   logic fifo_flush;
   logic grant_act;
   logic rx_in_ready;
   uhp_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_rx_fifo (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .flush(1'b0),
      .in_data(wdat_q),
      .in_valid(wr_go && !is_cmd),
      .in_ready(rx_in_ready),
      .out_data(rx_data),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .level()
   );
   logic [15:0] tx_head;
   logic tx_have;
   logic tx_pop;
   uhp_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_tx_fifo (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .flush(fifo_flush),
      .in_data(tx_data),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .out_data(tx_head),
      .out_valid(tx_have),
      .out_ready(tx_pop),
      .level()
   );
   assign tx_pop = rd_end && !is_cmd;

   // ----------------------------------------------------------------
   // Data bus drivers
   // ----------------------------------------------------------------
   logic [15:0] rdat_q;
   logic drive_q;
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rdat_q <= 16'h0000;
         drive_q <= 1'b0;
      end
      else
      begin
         drive_q <= live && cs_s && rd_s;
         if (rd_go)
         begin
            rdat_q <= is_cmd ? cmd_rd_data : (tx_have ? tx_head : 16'h0000);
         end
      end
   end
   assign data_out = narrow ? {8'h00, rdat_q[7:0]} : rdat_q;
   // Muxed mode hands bit zero to the shared line.
   assign data_oe = !drive_q ? 16'h0000 :
                    {{8{!narrow}}, 7'h7f, !muxed_mode};
   assign muxed_addr_data_line0_out = rdat_q[0];
   assign muxed_addr_data_line0_oe = drive_q && muxed_mode;

   // ----------------------------------------------------------------
   // DMA handshake
   // ----------------------------------------------------------------
   uhp_pkg::uhp_dma_state_t dma_q;
   logic fin_act;
   assign grant_act = (grant_s == dma_grant_pol);
   assign fin_act = (fin_s == dma_finish_pol);
   assign dma_state_xfer = (dma_q == uhp_pkg::DMA_XFER);
   assign fifo_flush = dma_state_xfer && fin_act;
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dma_q <= uhp_pkg::DMA_IDLE;
         dma_done <= 1'b0;
      end
      else
      begin
         dma_done <= 1'b0;
         unique case (dma_q)
            uhp_pkg::DMA_IDLE:
            begin
               if (live && dma_enable && tx_have)
               begin
                  dma_q <= uhp_pkg::DMA_REQ;
               end
            end
            uhp_pkg::DMA_REQ:
            begin
               if (grant_act)
               begin
                  dma_q <= uhp_pkg::DMA_XFER;
               end
               else if (!dma_enable)
               begin
                  dma_q <= uhp_pkg::DMA_IDLE;
               end
            end
            uhp_pkg::DMA_XFER:
            begin
               if (fin_act || !tx_have)
               begin
                  dma_q <= uhp_pkg::DMA_IDLE;
                  dma_done <= 1'b1;
               end
            end
            default:
            begin
               dma_q <= uhp_pkg::DMA_IDLE;
            end
         endcase
      end
   end
   logic req_q;
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         req_q <= 1'b0;
      end
      else
      begin
         req_q <= (dma_q == uhp_pkg::DMA_REQ);
      end
   end
   assign dma_request_out = req_q ~^ dma_req_pol;

   // ----------------------------------------------------------------
   // Interrupt output
   // ----------------------------------------------------------------
   logic int_lvl_q;
   logic [2:0] int_cnt_q;
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         int_lvl_q <= 1'b0;
         int_cnt_q <= 3'h0;
      end
      else
      begin
         if (int_event)
         begin
            int_lvl_q <= 1'b1;
         end
         else if (ctl_s[0])
         begin
            int_lvl_q <= 1'b0;
         end
         if (int_event)
         begin
            int_cnt_q <= 3'(uhp_pkg::INT_PULSE_CYC);
         end
         else if (int_cnt_q != 3'h0)
         begin
            int_cnt_q <= int_cnt_q - 3'h1;
         end
      end
   end
   logic int_raw;
   assign int_raw = int_pulse_mode ? (int_cnt_q != 3'h0) : int_lvl_q;
   assign int_out = int_raw ~^ int_active_high;

   // ----------------------------------------------------------------
   // Programmable clock output
   // ----------------------------------------------------------------
   logic [7:0] div_q;
   logic pclk_q;
   // Toggles every clk_div+1 cycles.
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         div_q <= uhp_pkg::CLKDIV_RST;
         pclk_q <= 1'b0;
      end
      else if (div_q >= clk_div)
      begin
         div_q <= 8'h00;
         pclk_q <= ~pclk_q;
      end
      else
      begin
         div_q <= div_q + 8'h01;
      end
   end
   assign prog_clock_output = pclk_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_req_polarity: assert property (@(posedge core_clk) disable iff (!rst_b)
      (dma_q == uhp_pkg::DMA_REQ) |=> (dma_request_out == dma_req_pol))
      else $error("request level wrong");
   a_finish_ends: assert property (@(posedge core_clk) disable iff (!rst_b)
      (dma_state_xfer && fin_act) |=> (dma_q == uhp_pkg::DMA_IDLE) && dma_done)
      else $error("finish did not end transfer");
   a_grant_start: assert property (@(posedge core_clk) disable iff (!rst_b)
      (dma_q == uhp_pkg::DMA_REQ && grant_act) |=> dma_state_xfer)
      else $error("grant ignored");
   a_int_pulse_len: assert property (@(posedge core_clk) disable iff (!rst_b)
      (int_event && int_pulse_mode && !int_active_high) ##1 !int_event [*5] |->
      int_out == 1'b1)
      else $error("pulse too long");
   a_ale_latch: assert property (@(posedge core_clk) disable iff (!rst_b)
      (muxed_mode && ale_d_q && !ale_s) |=> addr_q == $past(line0_s))
      else $error("address not latched");
   a_bus_release: assert property (@(posedge core_clk) disable iff (!rst_b)
      !(cs_s && rd_s) |=> data_oe == 16'h0000 && !muxed_addr_data_line0_oe)
      else $error("bus driven without read");
   a_cs_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
      !cs_s |-> !cmd_rd_pulse && !rd_go)
      else $error("access without select");
   a_sep_select: assert property (@(posedge core_clk) disable iff (!rst_b)
      !muxed_mode |-> is_cmd == sel_s)
      else $error("select not followed");
endmodule

// ===== uhp_pkg.sv
package uhp_pkg;
   // ----------------------------------------------------------------
   // Bus configuration codes
   // ----------------------------------------------------------------
   localparam logic [1:0] CFG_MODE16 = 2'h0;
   localparam logic [1:0] CFG_MODE8 = 2'h2;
   // ----------------------------------------------------------------
   // Reset values and timing counts
   // ----------------------------------------------------------------
   localparam logic [7:0] CLKDIV_RST = 8'h00;
   localparam int FIFO_DEPTH = 32;
   localparam int DATA_W = 16;
   localparam int INT_PULSE_NS = 100;
   localparam int CLK_PERIOD_NS = 25;
   localparam int INT_PULSE_CYC = (INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POR_CYC = 16;
   localparam int SYNC_STAGES = 3;
   // ----------------------------------------------------------------
   // DMA engine states
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      DMA_IDLE = 3'b001,
      DMA_REQ = 3'b010,
      DMA_XFER = 3'b100
   } uhp_dma_state_t;
endpackage

// ===== uhp_sync.sv
`timescale 1ns/1ps
module uhp_sync #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   // Three stages; the output moves only when stages two and three agree.
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         pin_out <= '0;
      end
      else
      begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < WIDTH; i++)
         begin
            if (s2_q[i] == s3_q[i])
            begin
               pin_out[i] <= s3_q[i];
            end
         end
      end
   end
endmodule
